// *** agu_pkg.sv ***
package agu_pkg;
	localparam int AGU_XLEN         = 32;
	localparam int AGU_NUM_GPR      = 32;
	localparam int AGU_IDX_W        = 5;
	localparam int AGU_PAGE_W       = 12;
	localparam int AGU_PAGE_NUM_W   = 20;
	localparam int AGU_TLB_DEPTH    = 4;
	localparam logic [31:0] AGU_INSN_BYTES = 32'h0000_0004;
	localparam logic [31:0] AGU_RESET_PC   = 32'hFFFF_FFFC;

	typedef enum logic [1:0] {
		AGU_DM_IMM  = 2'b00,
		AGU_DM_IDX  = 2'b01,
		AGU_DM_IND  = 2'b11
	} agu_dmode_e;

	typedef enum logic [2:0] {
		AGU_NM_SEQ  = 3'b000,
		AGU_NM_REL  = 3'b001,
		AGU_NM_ABS  = 3'b011,
		AGU_NM_LR   = 3'b010,
		AGU_NM_CTR  = 3'b110
	} agu_nmode_e;

	typedef enum logic [1:0] {
		AGU_ST_IDLE = 2'b00,
		AGU_ST_XLAT = 2'b01,
		AGU_ST_WB   = 2'b11
	} agu_state_e;
endpackage

// *** agu_xlat_if.sv ***
`timescale 1ns/1ps
interface agu_xlat_if;
	import agu_pkg::*;
	logic [AGU_XLEN-1:0] vaddr;
	logic                enable;
	logic [AGU_XLEN-1:0] paddr;
	logic                hit;
	modport core (output vaddr, output enable, input paddr, input hit);
	modport xlat (input vaddr, input enable, output paddr, output hit);
endinterface

// *** agu_xlat.sv ***
`timescale 1ns/1ps
// small fully associative page map; a miss leaves the address untranslated
// and flags it so the caller can fault
module agu_xlat
	import agu_pkg::*;
#(
	parameter int DEPTH = AGU_TLB_DEPTH
) (
	// clock and reset
	input  wire logic                        clock,
	input  wire logic                        reset_n,
	// entry load
	input  wire logic                        load,
	input  wire logic [$clog2(DEPTH)-1:0]    load_slot,
	input  wire logic [AGU_PAGE_NUM_W-1:0]   load_vpn,
	input  wire logic [AGU_PAGE_NUM_W-1:0]   load_ppn,
	// lookup
	agu_xlat_if.xlat                         port
);
	logic [AGU_PAGE_NUM_W-1:0] vpn_q [DEPTH];
	logic [AGU_PAGE_NUM_W-1:0] ppn_q [DEPTH];
	logic [DEPTH-1:0]          val_q;
	logic [DEPTH-1:0]          val_d;

	always_comb begin
		val_d = val_q;
		if (load)
			val_d[load_slot] = 1'b1;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			val_q <= '0;
		else
			val_q <= val_d;
	end

	always_ff @(posedge clock) begin
		if (load) begin
			vpn_q[load_slot] <= load_vpn;
			ppn_q[load_slot] <= load_ppn;
		end
	end

	always_comb begin
		port.paddr = port.vaddr;
		port.hit   = !port.enable;
		if (port.enable) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (val_q[i] &&
				    vpn_q[i] == port.vaddr[AGU_XLEN-1:AGU_PAGE_W]) begin
					port.paddr = {ppn_q[i],
					              port.vaddr[AGU_PAGE_W-1:0]};
					port.hit   = 1'b1;
				end
			end
		end
	end
endmodule // agu_xlat

// *** agu_top.sv ***
`timescale 1ns/1ps
module agu_top
	import agu_pkg::*;
#(
	parameter int TLB_DEPTH = AGU_TLB_DEPTH
) (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// operating state
	input  wire logic                      privileged,
	input  wire logic                      xlat_on,
	// data address request
	input  wire logic                      dreq_valid,
	input  wire logic [1:0]                dreq_mode,
	input  wire logic                      dreq_update,
	input  wire logic [AGU_IDX_W-1:0]      dreq_base,
	input  wire logic [AGU_IDX_W-1:0]      dreq_index,
	input  wire logic [15:0]               dreq_disp,
	input  wire logic                      dreq_priv_op,
	output logic                           dreq_ready,
	// data address answer
	output logic                           dres_valid,
	output logic [AGU_XLEN-1:0]            dres_addr,
	output logic                           dres_fault,
	output logic                           dres_priv_fault,
	// general register writes from the core
	input  wire logic                      gwr_en,
	input  wire logic [AGU_IDX_W-1:0]      gwr_idx,
	input  wire logic [AGU_XLEN-1:0]       gwr_data,
	// general register read port
	input  wire logic [AGU_IDX_W-1:0]      grd_idx,
	output logic [AGU_XLEN-1:0]            grd_data,
	// link and count registers
	input  wire logic                      lr_wr,
	input  wire logic                      ctr_wr,
	input  wire logic [AGU_XLEN-1:0]       spr_wdata,
	// instruction flow
	input  wire logic                      step,
	input  wire logic [2:0]                next_mode,
	input  wire logic [23:0]               branch_field,
	output logic [AGU_XLEN-1:0]            pc,
	output logic [AGU_XLEN-1:0]            fetch_addr,
	output logic                           fetch_fault,
	// translation entry load, privileged only
	input  wire logic                      tlb_load,
	input  wire logic [$clog2(TLB_DEPTH)-1:0] tlb_slot,
	input  wire logic [AGU_PAGE_NUM_W-1:0] tlb_vpn,
	input  wire logic [AGU_PAGE_NUM_W-1:0] tlb_ppn,
	output logic                           tlb_refused
);
	// wraps naturally: the 33rd bit is dropped on purpose
	function automatic logic [AGU_XLEN-1:0] add32(
		input logic [AGU_XLEN-1:0] a,
		input logic [AGU_XLEN-1:0] b
	);
		add32 = a + b;
	endfunction

	function automatic logic [AGU_XLEN-1:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction

	logic [AGU_XLEN-1:0] gpr_q [AGU_NUM_GPR];
	logic [AGU_XLEN-1:0] lr_q, lr_d, ctr_q, ctr_d;
	logic [AGU_XLEN-1:0] pc_q, pc_d;
	logic [AGU_XLEN-1:0] ea_q, ea_d;
	logic [AGU_IDX_W-1:0] wb_idx_q, wb_idx_d;
	logic                 wb_pend_q, wb_pend_d;
	agu_state_e           st_q, st_d;
	logic                 dv_q, dv_d, df_q, df_d, dp_q, dp_d;
	logic [AGU_XLEN-1:0]  da_q, da_d;
	logic [AGU_XLEN-1:0]  ea_c;
	logic                 tr_q, tr_d;
	logic                 tlb_go;

	agu_xlat_if dx ();
	agu_xlat_if ix ();

	// each port keeps its own copy of the map, loaded together; costs area
	// but gives data and fetch lookups in the same cycle without a mux
	agu_xlat #(.DEPTH(TLB_DEPTH)) u_dxlat (
		.clock     (clock),
		.reset_n   (reset_n),
		.load      (tlb_go),
		.load_slot (tlb_slot),
		.load_vpn  (tlb_vpn),
		.load_ppn  (tlb_ppn),
		.port      (dx.xlat)
	);
	agu_xlat #(.DEPTH(TLB_DEPTH)) u_ixlat (
		.clock     (clock),
		.reset_n   (reset_n),
		.load      (tlb_go),
		.load_slot (tlb_slot),
		.load_vpn  (tlb_vpn),
		.load_ppn  (tlb_ppn),
		.port      (ix.xlat)
	);

	assign tlb_go = tlb_load && privileged;

	// effective address
	always_comb begin
		case (agu_dmode_e'(dreq_mode))
			AGU_DM_IMM: ea_c = add32(gpr_q[dreq_base],
			                         sext16(dreq_disp));
			AGU_DM_IDX: ea_c = add32(gpr_q[dreq_base],
			                         gpr_q[dreq_index]);
			AGU_DM_IND: ea_c = gpr_q[dreq_base];
			default:    ea_c = gpr_q[dreq_base];
		endcase
	end

	assign dx.vaddr = ea_q;
	assign dx.enable = xlat_on;
	assign ix.vaddr = pc_q;
	assign ix.enable = xlat_on;

	// data request sequencer: capture, translate, write back
	always_comb begin
		st_d      = st_q;
		ea_d      = ea_q;
		wb_idx_d  = wb_idx_q;
		wb_pend_d = wb_pend_q;
		dv_d      = 1'b0;
		da_d      = da_q;
		df_d      = df_q;
		dp_d      = dp_q;
		tr_d      = 1'b0;
		case (st_q)
			AGU_ST_IDLE: begin
				if (dreq_valid) begin
					if (dreq_priv_op && !privileged) begin
						dv_d = 1'b1;
						dp_d = 1'b1;
						df_d = 1'b0;
						da_d = '0;
					end else begin
						ea_d      = ea_c;
						wb_idx_d  = dreq_base;
						// mode 10 decodes as indirect, so it never writes back
						wb_pend_d = dreq_update && !dreq_mode[1];
						st_d      = AGU_ST_XLAT;
					end
				end
			end
			AGU_ST_XLAT: begin
				dv_d = 1'b1;
				dp_d = 1'b0;
				da_d = xlat_on ? dx.paddr : ea_q;
				df_d = !dx.hit;
				st_d = wb_pend_q ? AGU_ST_WB : AGU_ST_IDLE;
			end
			AGU_ST_WB: begin
				wb_pend_d = 1'b0;
				st_d      = AGU_ST_IDLE;
			end
			default: st_d = AGU_ST_IDLE;
		endcase
		if (tlb_load && !privileged)
			tr_d = 1'b1;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q      <= AGU_ST_IDLE;
			ea_q      <= '0;
			wb_idx_q  <= '0;
			wb_pend_q <= 1'b0;
			dv_q      <= 1'b0;
			da_q      <= '0;
			df_q      <= 1'b0;
			dp_q      <= 1'b0;
			tr_q      <= 1'b0;
		end else begin
			st_q      <= st_d;
			ea_q      <= ea_d;
			wb_idx_q  <= wb_idx_d;
			wb_pend_q <= wb_pend_d;
			dv_q      <= dv_d;
			da_q      <= da_d;
			df_q      <= df_d;
			dp_q      <= dp_d;
			tr_q      <= tr_d;
		end
	end

	assign dreq_ready      = (st_q == AGU_ST_IDLE);
	assign dres_valid      = dv_q;
	assign dres_addr       = da_q;
	assign dres_fault      = df_q;
	assign dres_priv_fault = dp_q;
	assign tlb_refused     = tr_q;

	// general registers; address write-back wins over a same-cycle core write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < AGU_NUM_GPR; i++)
				gpr_q[i] <= '0;
		end else if (st_q == AGU_ST_WB) begin
			gpr_q[wb_idx_q] <= ea_q;
		end else if (gwr_en) begin
			gpr_q[gwr_idx] <= gwr_data;
		end
	end

	assign grd_data = gpr_q[grd_idx];

	// next instruction address
	always_comb begin
		lr_d  = lr_wr ? spr_wdata : lr_q;
		ctr_d = ctr_wr ? spr_wdata : ctr_q;
		pc_d  = pc_q;
		if (step) begin
			case (agu_nmode_e'(next_mode))
				AGU_NM_SEQ: pc_d = add32(pc_q, AGU_INSN_BYTES);
				AGU_NM_REL: pc_d = add32(pc_q, {{6{branch_field[23]}},
				                   branch_field, 2'b00});
				AGU_NM_ABS: pc_d = {{6{branch_field[23]}},
				                   branch_field, 2'b00};
				AGU_NM_LR:  pc_d = {lr_q[31:2], 2'b00};
				AGU_NM_CTR: pc_d = {ctr_q[31:2], 2'b00};
				default:    pc_d = add32(pc_q, AGU_INSN_BYTES);
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pc_q  <= AGU_RESET_PC;
			lr_q  <= '0;
			ctr_q <= '0;
		end else begin
			pc_q  <= pc_d;
			lr_q  <= lr_d;
			ctr_q <= ctr_d;
		end
	end

	assign pc          = pc_q;
	assign fetch_addr  = xlat_on ? ix.paddr : pc_q;
	assign fetch_fault = !ix.hit;
endmodule // agu_top

// *** agu_sva.sv ***
`timescale 1ns/1ps
module agu_sva
	import agu_pkg::*;
(
	// clock, reset and state
	input wire logic        clock,
	input wire logic        reset_n,
	input wire logic        privileged,
	input wire logic        xlat_on,
	// data requests
	input wire logic        dreq_valid,
	input wire logic [1:0]  dreq_mode,
	input wire logic        dreq_update,
	input wire logic        dreq_priv_op,
	input wire logic        dreq_ready,
	input wire logic        dres_valid,
	input wire logic [31:0] dres_addr,
	input wire logic        dres_priv_fault,
	// instruction flow and map
	input wire logic        step,
	input wire logic [2:0]  next_mode,
	input wire logic [23:0] branch_field,
	input wire logic [31:0] pc,
	input wire logic [31:0] fetch_addr,
	input wire logic        fetch_fault,
	input wire logic        tlb_load,
	input wire logic        tlb_refused
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	wire take = dreq_valid && dreq_ready;
	wire deny = dreq_priv_op && !privileged;
	wire upd = dreq_update && !dreq_mode[1];
	wire [31:0] bofs = {{6{branch_field[23]}}, branch_field, 2'b00};
	sequence one_wait;
		!dreq_ready ##1 dreq_ready;
	endsequence
	sequence two_wait;
		!dreq_ready [*2] ##1 dreq_ready;
	endsequence
	chk_seq_step: assert property (
		step && next_mode == 3'b000 |=> pc == $past(pc) + AGU_INSN_BYTES)
		else $error("sequential pc wrong");
	chk_rel_branch: assert property (
		step && next_mode == 3'b001 |=> pc == $past(pc) + $past(bofs))
		else $error("relative target wrong");
	chk_abs_branch: assert property (
		step && next_mode == 3'b011 |=> pc == $past(bofs))
		else $error("absolute target wrong");
	chk_plain_ready: assert property (
		take && !deny && !upd |=> one_wait)
		else $error("busy window wrong");
	// a lost write-back step shows as a short busy window
	chk_update_busy: assert property (
		take && !deny && upd |=> two_wait)
		else $error("update busy window wrong");
	chk_answer_time: assert property (
		take && !deny |=> !dres_valid ##1 dres_valid)
		else $error("answer late or early");
	chk_priv_refuse: assert property (
		take && deny |=> dres_valid && dres_priv_fault && dres_addr == '0)
		else $error("user request not refused");
	chk_tlb_refuse: assert property (
		tlb_load |=> tlb_refused == !$past(privileged))
		else $error("map load refusal wrong");
	chk_real_fetch: assert property (
		!xlat_on |-> fetch_addr == pc && !fetch_fault)
		else $error("real mode fetch translated");
	chk_virt_offset: assert property (
		xlat_on |-> fetch_addr[11:0] == pc[11:0])
		else $error("page offset changed");
endmodule // agu_sva

bind agu_top agu_sva agu_sva_i (.*);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	import agu_pkg::*;
	logic clock, reset_n, privileged, xlat_on, dreq_valid, dreq_update;
	logic dreq_priv_op, dreq_ready, dres_valid, dres_fault, dres_priv_fault;
	logic gwr_en, lr_wr, ctr_wr, step, tlb_load, tlb_refused, fetch_fault;
	logic tok;
	logic [1:0]  dreq_mode, tlb_slot;
	logic [4:0]  dreq_base, dreq_index, gwr_idx, grd_idx;
	logic [15:0] dreq_disp;
	logic [2:0]  next_mode;
	logic [23:0] branch_field;
	logic [19:0] tlb_vpn, tlb_ppn, tv, tp;
	logic [31:0] dres_addr, gwr_data, grd_data, spr_wdata, pc, fetch_addr;
	logic [31:0] epc, lr, ctr;
	logic [31:0] gm[32] = '{default: '0};
	logic [33:0] expq[$];
	int error_cnt, n_tests;
	wire [33:0] dres_w = {dres_priv_fault, dres_fault, dres_addr};
	wire [33:0] fetch_w = {1'b0, fetch_fault, fetch_addr};
	agu_top agu_top_i (.*);
	initial begin
		clock = 0;
		forever #50 clock = ~clock;
	end
	task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// results are matched oldest first, one per answer pulse
	always @(negedge clock) begin
		if (dres_valid === 1'b1 && expq.size() == 0)
			chk("dres extra", 34'h0, 34'h1);
		else if (dres_valid === 1'b1)
			chk("dres", expq.pop_front(), dres_w);
	end
	task automatic settle;
		int k;
		for (k = 0; k < 20; k++) begin
			@(negedge clock);
			if (dreq_ready === 1'b1 && expq.size() == 0)
				return;
		end
		error_cnt++;
		final_report();
	endtask
	task automatic gw(logic [4:0] i, logic [31:0] v);
		{gwr_en, gwr_idx, gwr_data} = {1'b1, i, v};
		gm[i] = v;
		@(negedge clock);
		gwr_en = 0;
		@(negedge clock);
	endtask
	task automatic req(logic [1:0] m, logic u, po, logic [4:0] b, x,
		logic [15:0] d);
		logic [31:0] a;
		logic f, dn;
		dn = po && !privileged;
		a = m == 2'b00 ? gm[b] + {{16{d[15]}}, d} : gm[b];
		if (m == 2'b01)
			a = gm[b] + gm[x];
		f = xlat_on && !(tok && a[31:12] == tv);
		if (u && !m[1] && !dn)
			gm[b] = a;
		if (xlat_on && !f)
			a[31:12] = tp;
		expq.push_back(dn ? 34'h2_0000_0000 : {1'b0, f, a});
		{dreq_mode, dreq_update, dreq_priv_op} = {m, u, po};
		{dreq_base, dreq_index, dreq_disp, grd_idx} = {b, x, d, b};
		dreq_valid = 1;
		@(negedge clock);
		dreq_valid = 0;
		settle();
		chk("gpr", gm[b], grd_data);
	endtask
	task automatic stp(logic [2:0] nm);
		logic [31:0] o;
		branch_field = {nm == 3'b001, 23'($urandom)};
		o = {{6{branch_field[23]}}, branch_field, 2'b00};
		epc = nm == 3'b000 ? epc + 32'h4 : nm == 3'b001 ? epc + o :
			nm == 3'b011 ? o : nm == 3'b010 ? lr : ctr;
		{next_mode, step} = {nm, 1'b1};
		@(negedge clock);
		step = 0;
		chk("pc", epc, pc);
		@(negedge clock);
	endtask
	initial begin
		{privileged, xlat_on, dreq_valid, dreq_update, dreq_priv_op} = '0;
		{gwr_en, lr_wr, ctr_wr, step, tlb_load, tok} = '0;
		{dreq_mode, tlb_slot, dreq_base, dreq_index, gwr_idx} = '0;
		{grd_idx, dreq_disp, next_mode, branch_field, tlb_vpn} = '0;
		{tlb_ppn, tv, tp, gwr_data, spr_wdata} = '0;
		reset_n = 0;
		void'($urandom(15364));
		epc = AGU_RESET_PC;
		repeat (3) @(negedge clock);
		reset_n = 1;
		chk("pc reset", epc, pc);
		for (int i = 0; i < 32; i++)
			gw(i[4:0], $urandom);
		gw(5'd1, 32'hFFFF_FFF0);
		$display("gpr test done");
		privileged = 1;
		req(2'b00, 1'b0, 1'b0, 5'd1, 5'd0, 16'h0020);
		for (int k = 0; k < 16; k++)
			req(k[1:0], k[2], k[3], 5'($urandom), 5'($urandom),
				16'($urandom));
		privileged = 0;
		req(2'b00, 1'b1, 1'b1, 5'd3, 5'd0, 16'h0004);
		req(2'b01, 1'b1, 1'b0, 5'd3, 5'd4, 16'h0000);
		$display("data test done");
		{lr_wr, spr_wdata} = {1'b1, 32'($urandom)};
		lr = spr_wdata & ~32'h3;
		@(negedge clock);
		{lr_wr, ctr_wr, spr_wdata} = {2'b01, 32'($urandom)};
		ctr = spr_wdata & ~32'h3;
		@(negedge clock);
		ctr_wr = 0;
		repeat (3) begin
			stp(3'b000);
			stp(3'b001);
			stp(3'b011);
			stp(3'b010);
			stp(3'b110);
		end
		chk("fetch", {2'b00, epc}, fetch_w);
		$display("flow test done");
		privileged = 1;
		{tlb_load, tlb_slot, tlb_vpn, tlb_ppn} = {3'b101, 40'h12345_ABCDE};
		@(negedge clock);
		tlb_load = 0;
		chk("refused", 34'h0, {33'h0, tlb_refused});
		{tok, tv, tp} = {1'b1, 40'h12345_ABCDE};
		gw(5'd2, 32'h1234_5678);
		gw(5'd6, 32'h0000_1000);
		xlat_on = 1;
		req(2'b11, 1'b0, 1'b0, 5'd2, 5'd0, 16'h0000);
		req(2'b11, 1'b0, 1'b0, 5'd6, 5'd0, 16'h0000);
		{lr_wr, spr_wdata} = {1'b1, 32'h1234_5ABC};
		lr = 32'h1234_5ABC;
		@(negedge clock);
		lr_wr = 0;
		stp(3'b010);
		chk("fetch", {2'b00, tp, epc[11:0]}, fetch_w);
		stp(3'b011);
		chk("fetch", {2'b01, epc}, fetch_w);
		{privileged, tlb_load} = 2'b01;
		@(negedge clock);
		tlb_load = 0;
		chk("refused", 34'h1, {33'h0, tlb_refused});
		$display("virtual test done");
		final_report();
	end
endmodule // tb_top
